// ===== hdl/sbc_core.sv
/*
 * sbc_core: command decode and bank/device state tracking for a four-bank
 * synchronous dram. assumes the controller drives the command pins from
 * logic on i_mclk, so the pins are sampled without synchronisers.
 */
`timescale 1ns/1ps
`default_nettype none
module sbc_core
	import sbc_pkg::*;
#(
	parameter int CNT_W     = 8,
	parameter int ACT_CYCS  = ACT_CYC,
	parameter int PRE_CYCS  = PRE_CYC,
	parameter int RFC_CYCS  = RFC_CYC,
	parameter int MRD_CYCS  = MRD_CYC,
	parameter int XSR_CYCS  = XSR_CYC,
	parameter int BURST     = BURST_LEN,
	parameter int RD_LAT    = READ_LAT
)(
	input  wire logic                        i_mclk,
	input  wire logic                        i_sys_rst,
	input  wire logic                        i_cke,
	input  wire logic                        i_chip_sel_n,
	input  wire logic                        i_row_strobe_n,
	input  wire logic                        i_col_strobe_n,
	input  wire logic                        i_write_strobe_n,
	input  wire logic                        i_auto_precharge_addr_bit,
	input  wire logic                        i_bank_select_lo,
	input  wire logic                        i_bank_select_hi,
	output logic [NUM_BANKS*BANK_ST_W-1:0]   o_bank_state,
	output logic [2:0]                       o_dev_state,
	output logic                             o_all_idle,
	output logic                             o_cmd_taken,
	output logic [3:0]                       o_cmd_code,
	output logic [BANK_W-1:0]                o_cmd_bank,
	output logic                             o_cmd_ap,
	output logic                             o_cmd_illegal,
	output logic                             o_burst_active,
	output logic [BANK_W-1:0]                o_burst_bank,
	output logic                             o_rdq_valid,
	output logic [BANK_W-1:0]                o_rdq_bank,
	output logic                             o_wr_take
);

	////////////////////////////////////////////////////////////////////////
	// elaboration checks

	localparam int CNT_MAX = (1 << CNT_W) - 1;

	if (CNT_W < 2 || CNT_W > 16)
		$error("sbc_core: CNT_W out of range");
	if (ACT_CYCS < 1 || PRE_CYCS < 1 || RFC_CYCS < 1 ||
		MRD_CYCS < 1 || XSR_CYCS < 1)
		$error("sbc_core: delays must be at least one cycle");
	if (ACT_CYCS > CNT_MAX || PRE_CYCS > CNT_MAX || RFC_CYCS > CNT_MAX ||
		MRD_CYCS > CNT_MAX || XSR_CYCS > CNT_MAX || BURST > CNT_MAX)
		$error("sbc_core: counter too narrow for a delay");
	if (BURST < 1 || RD_LAT < 1)
		$error("sbc_core: burst length and read latency must be >= 1");

	localparam logic [CNT_W-1:0] ACT_LOAD = CNT_W'(ACT_CYCS - 1);
	localparam logic [CNT_W-1:0] PRE_LOAD = CNT_W'(PRE_CYCS - 1);
	localparam logic [CNT_W-1:0] RFC_LOAD = CNT_W'(RFC_CYCS - 1);
	localparam logic [CNT_W-1:0] MRD_LOAD = CNT_W'(MRD_CYCS - 1);
	localparam logic [CNT_W-1:0] XSR_LOAD = CNT_W'(XSR_CYCS - 1);
	localparam logic [CNT_W-1:0] BST_LOAD = CNT_W'(BURST - 1);

	////////////////////////////////////////////////////////////////////////
	// pin decode

	sbc_cmd_if cmd ();

	logic      cke_prev;
	sbc_dev_e  dev_state;
	wire logic sr_hold;

	// clock enable comes from controller logic on this clock
	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
			cke_prev <= 1'b1;
		else
			cke_prev <= i_cke;
	end

	assign sr_hold = (dev_state == DEV_SELF_REF) ||
		(dev_state == DEV_SR_EXIT);

	sbc_cmd_decode u_decode (
		.i_chip_sel_n              (i_chip_sel_n),
		.i_row_strobe_n            (i_row_strobe_n),
		.i_col_strobe_n            (i_col_strobe_n),
		.i_write_strobe_n          (i_write_strobe_n),
		.i_auto_precharge_addr_bit (i_auto_precharge_addr_bit),
		.i_bank_select_lo          (i_bank_select_lo),
		.i_bank_select_hi          (i_bank_select_hi),
		.i_cke                     (i_cke),
		.i_cke_prev                (cke_prev),
		.i_sr_hold                 (sr_hold),
		.cmd                       (cmd.dec)
	);

	////////////////////////////////////////////////////////////////////////
	// command class and bank view

	sbc_bank_e            bank_st [NUM_BANKS];
	logic [NUM_BANKS-1:0] idle_vec;
	logic [NUM_BANKS-1:0] preok_vec;
	logic [CNT_W-1:0]     burst_left;
	logic                 burst_wr;
	logic [BANK_W-1:0]    burst_bank;

	wire logic      is_act;
	wire logic      is_rd;
	wire logic      is_wr;
	wire logic      is_rdwr;
	wire logic      is_ref;
	wire logic      is_mode;
	wire logic      is_pre;
	wire logic      is_bst;
	wire logic      is_exec;
	wire sbc_bank_e tgt_st;
	wire sbc_bank_e bst_st;
	wire logic      tgt_open;
	wire logic      all_idle;
	wire logic      all_preok;
	wire logic      dev_free;
	wire logic      burst_active;

	assign is_act  = (cmd.code == CMD_ACTIVE);
	assign is_rd   = (cmd.code == CMD_READ);
	assign is_wr   = (cmd.code == CMD_WRITE);
	assign is_rdwr = is_rd | is_wr;
	assign is_ref  = (cmd.code == CMD_REFRESH);
	assign is_mode = (cmd.code == CMD_MODE);
	assign is_pre  = (cmd.code == CMD_PRECH);
	assign is_bst  = (cmd.code == CMD_BSTOP);
	// inhibit and nop never count as commands
	assign is_exec = (cmd.code != CMD_INHIBIT) && (cmd.code != CMD_NOP);

	// for activate, read, write and single-bank precharge only the target bank's own state matters
	assign tgt_st   = bank_st[cmd.bank];
	assign tgt_open = (tgt_st == BK_ROW_ACTIVE) ||
		(tgt_st == BK_READ) || (tgt_st == BK_WRITE);
	assign bst_st   = bank_st[burst_bank];
	assign all_idle  = &idle_vec;
	assign all_preok = &preok_vec;
	assign dev_free  = (dev_state == DEV_RUN);
	assign burst_active = (burst_left != '0);

	////////////////////////////////////////////////////////////////////////
	// legality: anything not listed here is ignored and flagged

	wire logic legal;
	wire logic take;
	wire logic illegal;
	wire logic pre_all;

	assign pre_all = is_pre & cmd.ap;
	assign legal =
		(is_act  & (tgt_st == BK_IDLE)) |
		(is_rdwr & tgt_open) |
		(is_pre  & ~cmd.ap & (tgt_open | (tgt_st == BK_IDLE))) |
		(pre_all & all_preok) |
		((is_ref | is_mode) & all_idle) |
		(is_bst  & burst_active &
			((bst_st == BK_READ) || (bst_st == BK_WRITE)));
	assign take    = is_exec & dev_free & legal;
	assign illegal = is_exec & ~take;

	////////////////////////////////////////////////////////////////////////
	// burst engine: one burst owns the data bus at a time

	wire logic burst_cut;
	wire logic burst_last;
	wire logic beat_old;
	wire logic rd_beat;
	logic [CNT_W-1:0] next_burst_left;

	// a new access, a stop or a precharge of its bank ends the old burst
	assign burst_cut = burst_active & take &
		(is_rdwr | is_bst |
		 (is_pre & (cmd.ap | (cmd.bank == burst_bank))));
	assign burst_last = burst_active & ~burst_cut & (burst_left == 1);
	assign beat_old   = burst_active & ~burst_cut;

	always_comb
	begin
		next_burst_left = burst_left;
		if (take & is_rdwr)
			next_burst_left = BST_LOAD;
		else if (burst_cut)
			next_burst_left = '0;
		else if (burst_active)
			next_burst_left = burst_left - 1'b1;
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			burst_left <= '0;
			burst_wr   <= 1'b0;
			burst_bank <= '0;
		end
		else
		begin
			burst_left <= next_burst_left;
			if (take & is_rdwr)
			begin
				burst_wr   <= is_wr;
				burst_bank <= cmd.bank;
			end
		end
	end

	// interrupted write loses the beat of the interrupting edge
	assign rd_beat = (take & is_rd) | (beat_old & ~burst_wr);

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
			o_wr_take <= 1'b0;
		else
			o_wr_take <= (take & is_wr) | (beat_old & burst_wr);
	end

	////////////////////////////////////////////////////////////////////////
	// read data ownership, delayed by the read latency

	logic              rdq_v [RD_LAT];
	logic [BANK_W-1:0] rdq_b [RD_LAT];
	wire  [BANK_W-1:0] rd_bank;

	assign rd_bank = (take & is_rd) ? cmd.bank : burst_bank;

	for (genvar s = 0; s < RD_LAT; s++)
	begin : g_rdq
		// stage 0 has no predecessor; keep the index in range
		localparam int PREV = (s == 0) ? 0 : s - 1;
		always_ff @(posedge i_mclk)
		begin
			if (i_sys_rst)
			begin
				rdq_v[s] <= 1'b0;
				rdq_b[s] <= '0;
			end
			else if (s == 0)
			begin
				rdq_v[s] <= rd_beat;
				rdq_b[s] <= rd_bank;
			end
			else
			begin
				rdq_v[s] <= rdq_v[PREV];
				rdq_b[s] <= rdq_b[PREV];
			end
		end
	end

	assign o_rdq_valid = rdq_v[RD_LAT-1];
	assign o_rdq_bank  = rdq_b[RD_LAT-1];

	////////////////////////////////////////////////////////////////////////
	// banks

	for (genvar b = 0; b < NUM_BANKS; b++)
	begin : g_bank
		wire logic hit;
		wire logic bend;

		assign hit  = (cmd.bank == BANK_W'(b));
		// auto-precharge bank starts precharge when its burst ends
		assign bend = burst_active && (burst_bank == BANK_W'(b)) &&
			(burst_last || burst_cut);

		sbc_bank #(
			.CNT_W    (CNT_W),
			.ACT_LOAD (ACT_LOAD),
			.PRE_LOAD (PRE_LOAD)
		) u_bank (
			.i_mclk      (i_mclk),
			.i_sys_rst   (i_sys_rst),
			.i_act       (take & is_act & hit),
			.i_rdwr      (take & is_rdwr & hit),
			.i_wr        (is_wr),
			.i_ap        (cmd.ap),
			.i_pre       (take & is_pre & (cmd.ap | hit)),
			.i_burst_end (bend),
			.o_state     (bank_st[b])
		);

		assign idle_vec[b]  = (bank_st[b] == BK_IDLE);
		assign preok_vec[b] = (bank_st[b] == BK_IDLE) ||
			(bank_st[b] == BK_ROW_ACTIVE) ||
			(bank_st[b] == BK_READ) || (bank_st[b] == BK_WRITE);
		assign o_bank_state[b*BANK_ST_W +: BANK_ST_W] = bank_st[b];
	end

	////////////////////////////////////////////////////////////////////////
	// device-wide waits, one shared counter

	logic [CNT_W-1:0] dev_cnt;
	sbc_dev_e         next_dev;
	logic [CNT_W-1:0] next_dev_cnt;
	wire logic        dev_done;

	assign dev_done = (dev_cnt == '0);

	always_comb
	begin
		next_dev     = dev_state;
		next_dev_cnt = dev_done ? dev_cnt : dev_cnt - 1'b1;
		unique case (dev_state)
			DEV_RUN:
			begin
				if (cmd.sr_entry && all_idle)
					next_dev = DEV_SELF_REF;
				else if (take & is_ref)
				begin
					next_dev     = DEV_REFRESH;
					next_dev_cnt = RFC_LOAD;
				end
				else if (take & is_mode)
				begin
					next_dev     = DEV_MODE_LOAD;
					next_dev_cnt = MRD_LOAD;
				end
				else if (take & pre_all)
				begin
					next_dev     = DEV_PRE_ALL;
					next_dev_cnt = PRE_LOAD;
				end
			end
			DEV_REFRESH, DEV_MODE_LOAD, DEV_PRE_ALL:
				if (dev_done)
					next_dev = DEV_RUN;
			DEV_SELF_REF:
				if (i_cke)
				begin
					next_dev     = DEV_SR_EXIT;
					next_dev_cnt = XSR_LOAD;
				end
			DEV_SR_EXIT:
				if (dev_done)
					next_dev = DEV_RUN;
			default:
				next_dev = DEV_RUN;
		endcase
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			dev_state <= DEV_RUN;
			dev_cnt   <= '0;
		end
		else
		begin
			dev_state <= next_dev;
			dev_cnt   <= next_dev_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registered status

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			o_cmd_taken    <= 1'b0;
			o_cmd_code     <= CMD_INHIBIT;
			o_cmd_bank     <= '0;
			o_cmd_ap       <= 1'b0;
			o_cmd_illegal  <= 1'b0;
			o_all_idle     <= 1'b1;
			o_burst_active <= 1'b0;
			o_burst_bank   <= '0;
		end
		else
		begin
			o_cmd_taken    <= take;
			o_cmd_code     <= cmd.code;
			o_cmd_bank     <= cmd.bank;
			o_cmd_ap       <= cmd.ap;
			o_cmd_illegal  <= illegal;
			o_all_idle     <= (next_dev == DEV_RUN) && all_idle;
			o_burst_active <= (next_burst_left != '0);
			o_burst_bank   <= (take & is_rdwr) ? cmd.bank : burst_bank;
		end
	end

	assign o_dev_state = dev_state;

endmodule : sbc_core
`default_nettype wire

// ===== hdl/sbc_pkg.sv
/*
 * sbc_pkg: shared constants and types for the sdram bank command logic.
 * assumes a single 40 MHz clock; times are in ns, counts derived here.
 */
package sbc_pkg;

	localparam int NUM_BANKS  = 4;
	localparam int BANK_W     = 2;
	localparam int BANK_ST_W  = 3;
	localparam int CLK_MHZ    = 40;

	// timing figures, plain defaults
	localparam int T_RCD_NS   = 20;
	localparam int T_RP_NS    = 20;
	localparam int T_RFC_NS   = 66;
	localparam int T_XSR_NS   = 75;
	localparam int T_MRD_CYC  = 2;
	localparam int READ_LAT   = 3;
	localparam int BURST_LEN  = 4;

	// least time: round up, never below one cycle
	function automatic int cyc_min(input int ns);
		int c;
		c = (ns * CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction : cyc_min

	localparam int ACT_CYC = cyc_min(T_RCD_NS);
	localparam int PRE_CYC = cyc_min(T_RP_NS);
	localparam int RFC_CYC = cyc_min(T_RFC_NS);
	localparam int XSR_CYC = cyc_min(T_XSR_NS);
	localparam int MRD_CYC = T_MRD_CYC;

	typedef enum logic [3:0] {
		CMD_INHIBIT = 4'h0,
		CMD_NOP     = 4'h1,
		CMD_ACTIVE  = 4'h2,
		CMD_READ    = 4'h3,
		CMD_WRITE   = 4'h4,
		CMD_REFRESH = 4'h5,
		CMD_MODE    = 4'h6,
		CMD_PRECH   = 4'h7,
		CMD_BSTOP   = 4'h8
	} sbc_cmd_e;

	// gray along idle-activating-active-read-write-ap-precharging
	typedef enum logic [BANK_ST_W-1:0] {
		BK_IDLE       = 3'h0,
		BK_ACTIVATING = 3'h1,
		BK_ROW_ACTIVE = 3'h3,
		BK_READ       = 3'h2,
		BK_WRITE      = 3'h6,
		BK_READ_AP    = 3'h7,
		BK_WRITE_AP   = 3'h5,
		BK_PRECHARGING = 3'h4
	} sbc_bank_e;

	typedef enum logic [2:0] {
		DEV_RUN       = 3'h0,
		DEV_REFRESH   = 3'h1,
		DEV_MODE_LOAD = 3'h3,
		DEV_PRE_ALL   = 3'h2,
		DEV_SELF_REF  = 3'h6,
		DEV_SR_EXIT   = 3'h7
	} sbc_dev_e;

endpackage : sbc_pkg

// ===== hdl/sbc_cmd_if.sv
/*
 * sbc_cmd_if: decoded command from the pin decoder to the state core.
 * assumes both ends sit on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface sbc_cmd_if;
	import sbc_pkg::*;
	sbc_cmd_e              code;
	logic [BANK_W-1:0]     bank;
	logic                  ap;
	logic                  sr_entry;

	modport dec  (output code, output bank, output ap, output sr_entry);
	modport core (input code, input bank, input ap, input sr_entry);
endinterface : sbc_cmd_if
`default_nettype wire

// ===== hdl/sbc_cmd_decode.sv
/*
 * sbc_cmd_decode: turns sampled command pin levels into a command code.
 * assumes pins come from controller logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module sbc_cmd_decode
	import sbc_pkg::*;
(
	input  wire logic  i_chip_sel_n,
	input  wire logic  i_row_strobe_n,
	input  wire logic  i_col_strobe_n,
	input  wire logic  i_write_strobe_n,
	input  wire logic  i_auto_precharge_addr_bit,
	input  wire logic  i_bank_select_lo,
	input  wire logic  i_bank_select_hi,
	input  wire logic  i_cke,
	input  wire logic  i_cke_prev,
	input  wire logic  i_sr_hold,
	sbc_cmd_if.dec     cmd
);

	wire logic [2:0] strobes;
	wire sbc_cmd_e   raw;
	wire logic       gate;

	assign strobes = {i_row_strobe_n, i_col_strobe_n, i_write_strobe_n};
	assign raw = i_chip_sel_n ? CMD_INHIBIT :
		(strobes == 3'h7) ? CMD_NOP :
		(strobes == 3'h3) ? CMD_ACTIVE :
		(strobes == 3'h5) ? CMD_READ :
		(strobes == 3'h4) ? CMD_WRITE :
		(strobes == 3'h1) ? CMD_REFRESH :
		(strobes == 3'h0) ? CMD_MODE :
		(strobes == 3'h2) ? CMD_PRECH : CMD_BSTOP;

	// decode only with clock enable held and no exit wait pending
	assign gate = i_cke_prev & i_cke & ~i_sr_hold;
	assign cmd.code = gate ? raw : CMD_INHIBIT;
	assign cmd.bank = {i_bank_select_hi, i_bank_select_lo};
	assign cmd.ap = i_auto_precharge_addr_bit;
	assign cmd.sr_entry = i_cke_prev & ~i_cke & (raw == CMD_REFRESH);

endmodule : sbc_cmd_decode
`default_nettype wire

// ===== hdl/sbc_bank.sv
/*
 * sbc_bank: state and timing of one bank.
 * assumes the core only sends commands legal for this bank's state.
 */
`timescale 1ns/1ps
`default_nettype none
module sbc_bank
	import sbc_pkg::*;
#(
	parameter int               CNT_W    = 8,
	parameter logic [CNT_W-1:0] ACT_LOAD = '0,
	parameter logic [CNT_W-1:0] PRE_LOAD = '0
)(
	input  wire logic       i_mclk,
	input  wire logic       i_sys_rst,
	input  wire logic       i_act,
	input  wire logic       i_rdwr,
	input  wire logic       i_wr,
	input  wire logic       i_ap,
	input  wire logic       i_pre,
	input  wire logic       i_burst_end,
	output var  sbc_bank_e  o_state
);

	logic [CNT_W-1:0] cnt;
	logic             ap_pc;
	sbc_bank_e        next_state;
	logic [CNT_W-1:0] next_cnt;
	logic             next_ap_pc;
	wire logic        cnt_done;

	assign cnt_done = (cnt == '0);

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			o_state <= BK_IDLE;
			cnt     <= '0;
			ap_pc   <= 1'b0;
		end
		else
		begin
			o_state <= next_state;
			cnt     <= next_cnt;
			ap_pc   <= next_ap_pc;
		end
	end

	always_comb
	begin
		next_state = o_state;
		next_cnt   = cnt_done ? cnt : cnt - 1'b1;
		next_ap_pc = ap_pc;
		unique case (o_state)
			BK_IDLE:
			begin
				// precharge to an idle bank changes nothing
				if (i_act)
				begin
					next_state = BK_ACTIVATING;
					next_cnt   = ACT_LOAD;
				end
			end
			BK_ACTIVATING:
				if (cnt_done)
					next_state = BK_ROW_ACTIVE;
			BK_ROW_ACTIVE, BK_READ, BK_WRITE:
			begin
				if (i_pre)
				begin
					next_state = BK_PRECHARGING;
					next_cnt   = PRE_LOAD;
				end
				else if (i_rdwr)
				begin
					next_ap_pc = 1'b0;
					if (i_ap)
						next_state = i_wr ? BK_WRITE_AP : BK_READ_AP;
					else
						next_state = i_wr ? BK_WRITE : BK_READ;
				end
				else if (i_burst_end && o_state != BK_ROW_ACTIVE)
					next_state = BK_ROW_ACTIVE;
			end
			BK_READ_AP, BK_WRITE_AP:
			begin
				// precharge time runs from the end of the burst
				if (ap_pc && cnt_done)
				begin
					next_state = BK_IDLE;
					next_ap_pc = 1'b0;
				end
				else if (!ap_pc && i_burst_end)
				begin
					next_ap_pc = 1'b1;
					next_cnt   = PRE_LOAD;
				end
			end
			BK_PRECHARGING:
				if (cnt_done)
					next_state = BK_IDLE;
		endcase
	end

endmodule : sbc_bank
`default_nettype wire

// ===== tb/sbc_ctl_model.sv
/*
 * sbc_ctl_model: controller side, turns a command into pin levels.
 * assumes the bench changes i_cmd at the falling edge.
 */
`timescale 1ns/1ps
`default_nettype none
module sbc_ctl_model
	import sbc_pkg::*;
(
	input  wire logic      i_mclk,
	input  wire sbc_cmd_e  i_cmd,
	output logic           o_chip_sel_n,
	output logic [2:0]     o_strobe_n
);
	logic [2:0] junk = 3'h5;
	// deselected strobes keep moving so stale levels never pass
	always_ff @(negedge i_mclk)
		junk <= ~junk + 3'h1;
	assign o_chip_sel_n = (i_cmd == CMD_INHIBIT);
	always_comb
	begin
		case (i_cmd)
		CMD_NOP:     o_strobe_n = 3'h7;
		CMD_ACTIVE:  o_strobe_n = 3'h3;
		CMD_READ:    o_strobe_n = 3'h5;
		CMD_WRITE:   o_strobe_n = 3'h4;
		CMD_REFRESH: o_strobe_n = 3'h1;
		CMD_MODE:    o_strobe_n = 3'h0;
		CMD_PRECH:   o_strobe_n = 3'h2;
		CMD_BSTOP:   o_strobe_n = 3'h6;
		default:     o_strobe_n = junk;
		endcase
	end
endmodule : sbc_ctl_model
`default_nettype wire

// ===== tb/sbc_core_checker.sv
/*
 * sbc_core_checker: port assertions for sbc_core.
 * assumes default counts: act 1, pre 1, refresh 3, mode 2.
 */
`timescale 1ns/1ps
`default_nettype none
module sbc_core_checker
	import sbc_pkg::*;
#(
	parameter int RD_LAT = READ_LAT
)(
	input wire logic        i_mclk,
	input wire logic        i_sys_rst,
	input wire logic        i_cke,
	input wire logic        i_chip_sel_n,
	input wire logic        i_row_strobe_n,
	input wire logic        i_col_strobe_n,
	input wire logic        i_write_strobe_n,
	input wire logic [11:0] o_bank_state,
	input wire logic [2:0]  o_dev_state,
	input wire logic        o_cmd_taken,
	input wire logic [3:0]  o_cmd_code,
	input wire logic [1:0]  o_cmd_bank,
	input wire logic        o_cmd_ap,
	input wire logic        o_cmd_illegal,
	input wire logic        o_rdq_valid,
	input wire logic [1:0]  o_rdq_bank
);
	default clocking dc @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);
	// one of the latency edges is already spent when taken shows
	localparam int RDQ_DLY = RD_LAT - 1;
	function automatic logic [2:0] st(input logic [11:0] v, input int b);
		return v[3*b +: 3];
	endfunction : st
	logic [3:0] pin_code;
	always_comb
	begin
		case ({i_row_strobe_n, i_col_strobe_n, i_write_strobe_n})
		3'h7: pin_code = 4'h1;
		3'h3: pin_code = 4'h2;
		3'h5: pin_code = 4'h3;
		3'h4: pin_code = 4'h4;
		3'h1: pin_code = 4'h5;
		3'h0: pin_code = 4'h6;
		3'h2: pin_code = 4'h7;
		default: pin_code = 4'h8;
		endcase
	end
	////////////////////////////////////////////////////////////////////////
	property p_inhibit;
		!$past(i_sys_rst) && $past(i_chip_sel_n) |->
			o_cmd_code == 4'h0 && !o_cmd_taken && !o_cmd_illegal;
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("deselect acted");
	property p_decode;
		!$past(i_sys_rst) && !$past(i_sys_rst, 2) && $past(i_cke, 2) &&
			!($past(o_dev_state) inside {3'h6, 3'h7}) &&
			$past(!i_chip_sel_n && i_cke) |-> o_cmd_code == $past(pin_code);
	endproperty
	a_decode: assert property (p_decode) else $error("bad decode");
	property p_act;
		o_cmd_taken && o_cmd_code == 4'h2 |-> st(o_bank_state, o_cmd_bank)
			== 3'h1 ##1 st(o_bank_state, $past(o_cmd_bank)) == 3'h3;
	endproperty
	a_act: assert property (p_act) else $error("activate timing");
	property p_cut;
		o_cmd_taken && o_cmd_code == 4'h7 && !o_cmd_ap &&
			st($past(o_bank_state), o_cmd_bank) inside {3'h2, 3'h6}
			|-> st(o_bank_state, o_cmd_bank) == 3'h4;
	endproperty
	a_cut: assert property (p_cut) else $error("burst not cut");
	property p_rfsh;
		o_cmd_taken && o_cmd_code == 4'h5 |-> $past(o_bank_state) == 12'h0
			##0 (o_dev_state == 3'h1) [*3] ##1 o_dev_state == 3'h0;
	endproperty
	a_rfsh: assert property (p_rfsh) else $error("refresh wrong");
	property p_mode;
		o_cmd_taken && o_cmd_code == 4'h6 |->
			(o_dev_state == 3'h3) [*2] ##1 o_dev_state == 3'h0;
	endproperty
	a_mode: assert property (p_mode) else $error("mode load wrong");
	property p_preall;
		o_cmd_taken && o_cmd_code == 4'h7 && o_cmd_ap |-> o_dev_state ==
			3'h2 ##1 o_dev_state == 3'h0 && o_bank_state == 12'h0;
	endproperty
	a_preall: assert property (p_preall) else $error("pre all wrong");
	property p_busy;
		$past(o_dev_state) != 3'h0 |-> !o_cmd_taken;
	endproperty
	a_busy: assert property (p_busy) else $error("taken while busy");
	property p_rdq;
		o_cmd_taken && o_cmd_code == 4'h3 |-> ##RDQ_DLY
			o_rdq_valid && o_rdq_bank == $past(o_cmd_bank, RDQ_DLY);
	endproperty
	a_rdq: assert property (p_rdq) else $error("read data late");
endmodule : sbc_core_checker
bind sbc_core sbc_core_checker #(.RD_LAT(RD_LAT)) i_chk (.i_mclk, .i_sys_rst,
	.i_cke, .i_chip_sel_n, .i_row_strobe_n, .i_col_strobe_n,
	.i_write_strobe_n, .o_bank_state, .o_dev_state, .o_cmd_taken,
	.o_cmd_code, .o_cmd_bank, .o_cmd_ap, .o_cmd_illegal, .o_rdq_valid,
	.o_rdq_bank);
`default_nettype wire

// ===== tb/test_sdram_bank_command_state_logic.sv
/*
 * bench for sbc_core: commands via the controller model, notes queued.
 * assumes default timing counts of sbc_pkg.
 */
`timescale 1ns/1ps
`default_nettype none
module test_sdram_bank_command_state_logic
	import sbc_pkg::*;
;
	typedef struct {logic [3:0] c; logic [1:0] t; time at;} sbc_note_s;
	sbc_note_s   q[$];
	sbc_note_s   n;
	sbc_cmd_e    cmd = CMD_NOP;
	logic        clk = 1'b0, rst = 1'b1, cke = 1'b1, ckq = 1'b1, ap = 1'b0;
	logic [1:0]  bank = 2'h0;
	logic [1:0]  bb;
	logic        cs_n, tk, il, idle, wt, ba, hold = 1'b0;
	logic [2:0]  stb, dst;
	logic [3:0]  code;
	logic [11:0] bst;
	int          mismatches = 0, checked = 0, seed = 77;
	initial
		forever #12.5 clk = ~clk;
	sbc_ctl_model i_ctl (.i_mclk(clk), .i_cmd(cmd), .o_chip_sel_n(cs_n),
		.o_strobe_n(stb));
	sbc_core i_dut (.i_mclk(clk), .i_sys_rst(rst), .i_cke(cke),
		.i_chip_sel_n(cs_n), .i_row_strobe_n(stb[2]),
		.i_col_strobe_n(stb[1]), .i_write_strobe_n(stb[0]),
		.i_auto_precharge_addr_bit(ap), .i_bank_select_lo(bank[0]),
		.i_bank_select_hi(bank[1]), .o_bank_state(bst), .o_dev_state(dst),
		.o_all_idle(idle), .o_cmd_taken(tk), .o_cmd_code(code),
		.o_cmd_bank(), .o_cmd_ap(), .o_cmd_illegal(il), .o_burst_active(ba),
		.o_burst_bank(bb), .o_rdq_valid(), .o_rdq_bank(), .o_wr_take(wt));
	////////////////////////////////////////////////////////////////////////
	task finish_test;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : finish_test
	task chk(input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e)
		begin
			mismatches++;
			$display("mismatch at %0t: saw %h expected %h", $time, s, e);
		end
	endtask : chk
	function automatic logic [2:0] bs(input int b);
		return bst[3*b +: 3];
	endfunction : bs
	// t is {taken, refused}; gated clock enable turns any note to inhibit
	task go(input sbc_cmd_e c, input logic [1:0] b, input logic a,
		input logic [1:0] t);
		sbc_note_s x;
		cmd = c;
		bank = b;
		ap = a;
		x.c = (cke && ckq && !hold) ? c : CMD_INHIBIT;
		x.t = t;
		x.at = $time;
		q.push_back(x);
		ckq = cke;
		@(negedge clk);
	endtask : go
	task rnd(input sbc_cmd_e c, input int k);
		repeat (k) go(c, 2'($random(seed)), 1'($random(seed)), 2'h0);
	endtask : rnd
	task settle(input int b, input int k);
		int i;
		for (i = 0; i < 40 && (bs(b) !== 3'h0 || dst !== 3'h0); i++)
			rnd(CMD_NOP, 1);
		chk(16'(i), 16'(k));
		if (i == 40)
			finish_test;
	endtask : settle
	always @(negedge clk)
		if (q.size() > 0 && q[0].at < $time)
		begin
			n = q.pop_front();
			chk(code, n.c);
			if (n.c > 4'h1)
				chk({tk, il}, n.t);
		end
	initial
	begin
		#100us;
		mismatches++;
		finish_test;
	end
	initial
	begin
		repeat (4) @(negedge clk);
		rst = 1'b0;
		chk({bst, dst, idle}, 16'h0001);
		go(CMD_ACTIVE, 2'h0, 1'b0, 2'h2);
		chk(bs(0), 3'h1);
		go(CMD_ACTIVE, 2'h1, 1'b0, 2'h2);
		chk(bs(0), 3'h3);
		go(CMD_ACTIVE, 2'h0, 1'b0, 2'h1);
		go(CMD_READ, 2'h0, 1'b0, 2'h2);
		chk({bs(0), ba}, 4'h5);
		go(CMD_READ, 2'h1, 1'b0, 2'h2);
		chk({bs(0), bs(1), bb}, 8'h69);
		go(CMD_BSTOP, 2'h0, 1'b0, 2'h2);
		chk({bs(1), ba}, 4'h6);
		go(CMD_WRITE, 2'h0, 1'b0, 2'h2);
		chk({bs(0), wt}, 4'hd);
		go(CMD_PRECH, 2'h0, 1'b0, 2'h2);
		chk({bs(0), wt}, 4'h8);
		go(CMD_READ, 2'h1, 1'b0, 2'h2);
		chk({bs(0), bs(1)}, 6'h02);
		go(CMD_PRECH, 2'h1, 1'b0, 2'h2);
		chk(bs(1), 3'h4);
		go(CMD_PRECH, 2'h0, 1'b0, 2'h2);
		chk(bs(0), 3'h0);
		go(CMD_READ, 2'h2, 1'b0, 2'h1);
		go(CMD_ACTIVE, 2'h2, 1'b0, 2'h2);
		rnd(CMD_INHIBIT, 1);
		go(CMD_WRITE, 2'h2, 1'b1, 2'h2);
		chk(bs(2), 3'h5);
		go(CMD_ACTIVE, 2'h2, 1'b0, 2'h1);
		settle(2, BURST_LEN + PRE_CYC - 2);
		go(CMD_REFRESH, 2'h0, 1'b0, 2'h2);
		chk(dst, 3'h1);
		go(CMD_ACTIVE, 2'h0, 1'b0, 2'h1);
		settle(0, RFC_CYC - 1);
		go(CMD_ACTIVE, 2'h3, 1'b0, 2'h2);
		go(CMD_MODE, 2'h0, 1'b0, 2'h1);
		go(CMD_PRECH, 2'h0, 1'b1, 2'h2);
		chk({dst, bs(3)}, 6'h14);
		settle(3, PRE_CYC);
		go(CMD_MODE, 2'h0, 1'b0, 2'h2);
		chk(dst, 3'h3);
		settle(0, MRD_CYC);
		go(CMD_BSTOP, 2'h0, 1'b0, 2'h1);
		cke = 1'b0;
		go(CMD_ACTIVE, 2'h0, 1'b0, 2'h0);
		cke = 1'b1;
		go(CMD_ACTIVE, 2'h0, 1'b0, 2'h0);
		chk(bs(0), 3'h0);
		cke = 1'b0;
		go(CMD_REFRESH, 2'h0, 1'b0, 2'h0);
		chk(dst, 3'h6);
		{cke, hold} = 2'h3;
		rnd(CMD_ACTIVE, XSR_CYC + 1);
		hold = 1'b0;
		chk({dst, bs(0)}, 6'h00);
		go(CMD_ACTIVE, 2'h0, 1'b0, 2'h2);
		rnd(CMD_INHIBIT, 8);
		chk(bs(0), 3'h3);
		rst = 1'b1;
		rnd(CMD_INHIBIT, 2);
		chk(bst, 12'h0);
		rst = 1'b0;
		rnd(CMD_NOP, 2);
		@(posedge clk);
		finish_test;
	end
endmodule : test_sdram_bank_command_state_logic
`default_nettype wire
